// *** design/spdenc_encoder.sv ***
// subframe encoder top: registers, frame sequencing and subframe assembly
`timescale 1ns/100ps
`default_nettype none

module spdenc_encoder #(
  parameter int unsigned BLOCK_FRAMES = spdenc_pkg::BLOCK_FRAMES
) (
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic [7:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic [31:0]      AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  output logic             TX_LINE_O
);

  if (BLOCK_FRAMES < 2 || BLOCK_FRAMES > spdenc_pkg::CHST_BITS) begin : g_bad
    $error("BLOCK_FRAMES out of range");
  end

  localparam logic [7:0] FRAME_LAST = 8'(BLOCK_FRAMES - 1);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    spdenc_pkg::spdenc_run_t  run;
    spdenc_pkg::spdenc_ctrl_t ctrl;
    logic [6:0]               ui;
    logic [7:0]               frame;
    spdenc_pkg::spdenc_chan_t hold_l;
    spdenc_pkg::spdenc_chan_t hold_r;
    spdenc_pkg::spdenc_chan_t work_l;
    spdenc_pkg::spdenc_chan_t work_r;
    logic                     pend;
    logic                     under;
    logic                     tog;
    logic                     ack;
    logic [31:0]              rdata;
    logic [1:0][spdenc_pkg::CHST_WORDS-1:0][31:0] chst;
  } spdenc_enc_st_t;

  spdenc_enc_st_t           s_q;
  spdenc_enc_st_t           s_d;
  logic                     acc;
  logic                     sel_smp;
  logic                     stall;
  logic                     done;
  logic                     wr;
  logic                     active;
  logic                     frame_end;
  logic                     sub;
  logic [2:0]               cs_idx;
  logic                     cs_hit_a;
  logic                     cs_hit_b;
  logic [31:0]              wmerge;
  logic [31:0]              rd_mux;
  logic [31:0]              word;
  spdenc_pkg::spdenc_chan_t cur;
  spdenc_pkg::spdenc_pre_t  pre;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] build(input spdenc_pkg::spdenc_chan_t ch,
                                        input spdenc_pkg::spdenc_ctrl_t c,
                                        input logic                     vov,
                                        input logic                     csb);
    logic [31:0] w;
    logic [4:0]  wid;
    logic [4:0]  cut;
    logic [23:0] s;
    w   = '0;
    wid = c.mode24 ? spdenc_pkg::WIDTH_24 : spdenc_pkg::WIDTH_20;
    if (c.width < wid) begin
      wid = c.width;
    end
    cut = spdenc_pkg::WIDTH_24 - wid;
    s   = ch.smp;
    for (int i = 0; i < 24; i++) begin
      if (5'(i) < cut) begin
        s[i] = 1'b0;
      end
    end
    if (c.mode24) begin
      w[27:4] = s;
    end else begin
      w[27:8] = s[23:4];
      w[7:4]  = ch.side.aux;
    end
    w[spdenc_pkg::SLOT_VALID]  = ch.side.valid | vov;
    w[spdenc_pkg::SLOT_USER]   = ch.side.user;
    w[spdenc_pkg::SLOT_CHST]   = csb;
    w[spdenc_pkg::SLOT_PARITY] = ^w[30:4];
    return w;
  endfunction

  // ************************************************************
  // bus slave
  // ************************************************************
  assign acc       = AVS_READ_I | AVS_WRITE_I;
  assign active    = (s_q.run == spdenc_pkg::RUN_ACTIVE);
  assign sel_smp   = (AVS_ADDRESS_I == spdenc_pkg::OFS_LEFT)
                   | (AVS_ADDRESS_I == spdenc_pkg::OFS_RIGHT);
  assign stall     = AVS_WRITE_I & sel_smp & s_q.pend & active;
  assign done      = acc & s_q.ack & ~stall;
  assign wr        = AVS_WRITE_I & done;
  assign wmerge    = AVS_WRITEDATA_I;
  assign cs_idx    = AVS_ADDRESS_I[4:2];
  assign cs_hit_a  = (AVS_ADDRESS_I[7:5] == spdenc_pkg::OFS_CHST_A[7:5])
                   & (cs_idx < 3'(spdenc_pkg::CHST_WORDS));
  assign cs_hit_b  = (AVS_ADDRESS_I[7:5] == spdenc_pkg::OFS_CHST_B[7:5])
                   & (cs_idx < 3'(spdenc_pkg::CHST_WORDS));
  assign AVS_WAITREQUEST_O = acc & ~done;
  assign AVS_READDATA_O    = s_q.rdata;

  always_comb begin
    rd_mux = '0;
    if (AVS_ADDRESS_I == spdenc_pkg::OFS_CTRL) begin
      rd_mux = s_q.ctrl;
    end else if (AVS_ADDRESS_I == spdenc_pkg::OFS_STAT) begin
      rd_mux = {21'h0, active, s_q.frame, s_q.under, s_q.pend};
    end else if (AVS_ADDRESS_I == spdenc_pkg::OFS_LEFT) begin
      rd_mux = {8'h0, s_q.hold_l.smp};
    end else if (AVS_ADDRESS_I == spdenc_pkg::OFS_RIGHT) begin
      rd_mux = {8'h0, s_q.hold_r.smp};
    end else if (AVS_ADDRESS_I == spdenc_pkg::OFS_SIDE) begin
      rd_mux = {20'h0, s_q.hold_r.side, s_q.hold_l.side};
    end else if (cs_hit_a) begin
      rd_mux = s_q.chst[0][cs_idx];
    end else if (cs_hit_b) begin
      rd_mux = s_q.chst[1][cs_idx];
    end
  end

  // ************************************************************
  // subframe assembly
  // ************************************************************
  assign sub       = s_q.ui[6];
  assign frame_end = active & (s_q.ui == spdenc_pkg::UI_FRAME_LAST);
  assign cur       = sub ? s_q.work_r : s_q.work_l;
  assign pre       = sub ? spdenc_pkg::PRE_Y
                   : (s_q.frame == 8'h00) ? spdenc_pkg::PRE_Z
                   : spdenc_pkg::PRE_X;
  assign word      = build(cur, s_q.ctrl,
                           s_q.ctrl.channel_status_buffer_enable
                           & (sub ? s_q.ctrl.val_b : s_q.ctrl.val_a),
                           s_q.chst[sub][s_q.frame[7:5]][s_q.frame[4:0]]);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_d     = s_q;
    s_d.ack = acc & ~done;
    if (AVS_READ_I && !s_q.ack) begin
      s_d.rdata = rd_mux;
    end
    // frame sequencing, one unit interval per clock
    unique case (s_q.run)
      spdenc_pkg::RUN_IDLE: begin
        s_d.ui    = '0;
        s_d.frame = '0;
        if (s_q.ctrl.enable) begin
          s_d.run = spdenc_pkg::RUN_ACTIVE;
          if (s_q.pend) begin
            s_d.work_l = s_q.hold_l;
            s_d.work_r = s_q.hold_r;
            s_d.pend   = 1'b0;
          end
        end
      end
      spdenc_pkg::RUN_ACTIVE: begin
        if (!s_q.ctrl.enable) begin
          s_d.run   = spdenc_pkg::RUN_IDLE;
          s_d.ui    = '0;
          s_d.frame = '0;
        end else begin
          s_d.ui = s_q.ui + 7'h01;
          if (frame_end) begin
            s_d.frame = (s_q.frame == FRAME_LAST) ? 8'h00 : s_q.frame + 8'h01;
            if (s_q.pend) begin
              s_d.work_l = s_q.hold_l;
              s_d.work_r = s_q.hold_r;
              s_d.pend   = 1'b0;
            end
          end
        end
      end
    endcase
    // register writes
    if (wr) begin
      if (AVS_ADDRESS_I == spdenc_pkg::OFS_CTRL) begin
        s_d.ctrl      = be_merge(s_q.ctrl, wmerge, AVS_BYTEENABLE_I);
        s_d.ctrl.rsvd = '0;
      end else if (AVS_ADDRESS_I == spdenc_pkg::OFS_STAT) begin
        if (AVS_BYTEENABLE_I[0] && wmerge[spdenc_pkg::STAT_UNDER_BIT]) begin
          s_d.under = 1'b0;
        end
      end else if (AVS_ADDRESS_I == spdenc_pkg::OFS_LEFT) begin
        if (s_q.ctrl.single_channel_double_rate && s_q.tog) begin
          s_d.hold_r.smp = wmerge[23:0];
          s_d.pend       = 1'b1;
          s_d.tog        = 1'b0;
        end else begin
          s_d.hold_l.smp = wmerge[23:0];
          s_d.tog        = s_q.ctrl.single_channel_double_rate;
        end
      end else if (AVS_ADDRESS_I == spdenc_pkg::OFS_RIGHT) begin
        s_d.hold_r.smp = wmerge[23:0];
        s_d.pend       = 1'b1;
        s_d.tog        = 1'b0;
      end else if (AVS_ADDRESS_I == spdenc_pkg::OFS_SIDE) begin
        s_d.hold_l.side = wmerge[5:0];
        s_d.hold_r.side = wmerge[11:6];
      end else if (cs_hit_a) begin
        s_d.chst[0][cs_idx] = be_merge(s_q.chst[0][cs_idx], wmerge, AVS_BYTEENABLE_I);
      end else if (cs_hit_b) begin
        s_d.chst[1][cs_idx] = be_merge(s_q.chst[1][cs_idx], wmerge, AVS_BYTEENABLE_I);
      end
    end
    // missing pair at frame end: sticky, set wins over clear
    if (frame_end && s_q.ctrl.enable && !s_q.pend) begin
      s_d.under = 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      s_q      <= '0;
      s_q.ctrl <= spdenc_pkg::CTRL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // line coder
  // ************************************************************
  spdenc_line u_line (
    .clk_i    (CLK_I),
    .rst_i    (SYS_RST_I),
    .run_i    (active),
    .ui_sub_i (s_q.ui[5:0]),
    .bit_i    (word[s_q.ui[5:1]]),
    .pre_i    (pre),
    .line_o   (TX_LINE_O)
  );

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  chk_frame_wrap: assert property (
    (frame_end && s_q.ctrl.enable)
    |=> (s_q.ui == 7'h00 && s_q.frame == (($past(s_q.frame) == FRAME_LAST)
                                          ? 8'h00 : $past(s_q.frame) + 8'h01))
  ) else $error("frame did not close after 128 unit intervals");

  chk_sub_half: assert property (
    (active && s_q.ui == spdenc_pkg::UI_SUB_LAST && s_q.ctrl.enable)
    |=> (sub && pre == spdenc_pkg::PRE_Y)
  ) else $error("second subframe not at 64 unit intervals");

  chk_block_z: assert property (
    (active && pre == spdenc_pkg::PRE_Z) |-> (s_q.frame == 8'h00 && !sub)
  ) else $error("Z preamble outside block start");

  chk_valid_force: assert property (
    (active && s_q.ctrl.channel_status_buffer_enable
     && (sub ? s_q.ctrl.val_b : s_q.ctrl.val_a)) |-> word[spdenc_pkg::SLOT_VALID]
  ) else $error("validity override not applied");

  chk_user_slot: assert property (
    active |-> (word[spdenc_pkg::SLOT_USER] == cur.side.user)
  ) else $error("user slot mismatch");

  chk_chst_first: assert property (
    (active && s_q.frame == 8'h00) |-> (word[spdenc_pkg::SLOT_CHST] == s_q.chst[sub][0][0])
  ) else $error("channel status bit 0 not in Z frame");

  chk_even_parity: assert property (
    active |-> !(^word[31:4])
  ) else $error("odd parity over slots 4 to 31");

  chk_zero_fill: assert property (
    (active && s_q.ctrl.mode24 && s_q.ctrl.width == 5'h10) |-> (word[11:4] == 8'h00)
  ) else $error("unused low bits not zero");

  chk_slot_20: assert property (
    (active && !s_q.ctrl.mode24 && s_q.ctrl.width >= spdenc_pkg::WIDTH_20)
    |-> (word[27:8] == cur.smp[23:4] && word[7:4] == cur.side.aux)
  ) else $error("20-bit placement wrong");

  chk_load_pair: assert property (
    (frame_end && s_q.pend && s_q.ctrl.enable)
    |=> (s_q.work_l == $past(s_q.hold_l) && s_q.work_r == $past(s_q.hold_r) && !s_q.pend)
  ) else $error("sample pair not loaded at frame end");

  cov_block_wrap: cover property (frame_end && s_q.frame == FRAME_LAST);
  cov_underrun:   cover property ($rose(s_q.under));
  cov_stall:      cover property (stall ##1 !stall && wr);
  cov_scdr_pair:  cover property (wr && s_q.ctrl.single_channel_double_rate && s_q.tog);

endmodule

`default_nettype wire

// *** design/spdenc_line.sv ***
// line coder: preambles and bi-phase mark for one subframe position per clock
`timescale 1ns/100ps
`default_nettype none

module spdenc_line (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     run_i,
  input  wire logic [5:0]               ui_sub_i,
  input  wire logic                     bit_i,
  input  wire spdenc_pkg::spdenc_pre_t  pre_i,
  output logic                          line_o
);

  // ************************************************************
  // state
  // ************************************************************
  spdenc_pkg::spdenc_line_st_t s_q;
  spdenc_pkg::spdenc_line_st_t s_d;
  logic [7:0]                  pat;
  logic                        base;

  always_comb begin
    unique case (pre_i)
      spdenc_pkg::PRE_X: pat = spdenc_pkg::PAT_X;
      spdenc_pkg::PRE_Y: pat = spdenc_pkg::PAT_Y;
      spdenc_pkg::PRE_Z: pat = spdenc_pkg::PAT_Z;
      default:           pat = spdenc_pkg::PAT_X;
    endcase
  end

  // ************************************************************
  // next line state
  // ************************************************************
  always_comb begin
    s_d      = s_q;
    base     = (ui_sub_i == 6'h00) ? s_q.line : s_q.prev;
    s_d.hist = {s_q.hist[5:0], s_q.line};
    if (!run_i) begin
      s_d.line = 1'b0;
      s_d.prev = 1'b0;
    end else if (ui_sub_i < spdenc_pkg::UI_DATA_FIRST) begin
      // preamble state, complemented after a high state
      s_d.line = pat[3'h7 - ui_sub_i[2:0]] ^ base;
      if (ui_sub_i == 6'h00) begin
        s_d.prev = s_q.line;
      end
    end else if (!ui_sub_i[0]) begin
      s_d.line = ~s_q.line;
    end else begin
      s_d.line = s_q.line ^ bit_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign line_o = s_q.line;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_bmc_lead_edge: assert property (
    (run_i && ui_sub_i >= spdenc_pkg::UI_DATA_FIRST && !ui_sub_i[0])
    |=> (line_o != $past(line_o))
  ) else $error("no transition at bit cell start");

  chk_bmc_mid_cell: assert property (
    (run_i && ui_sub_i >= spdenc_pkg::UI_DATA_FIRST && ui_sub_i[0])
    |=> ((line_o != $past(line_o)) == $past(bit_i))
  ) else $error("mid cell transition does not match data bit");

  chk_pre_first_flip: assert property (
    (run_i && ui_sub_i == 6'h00) |=> (line_o != $past(line_o))
  ) else $error("preamble does not start with a transition");

  chk_pre_pattern: assert property (
    (run_i && ui_sub_i == spdenc_pkg::UI_DATA_FIRST)
    |-> ({s_q.hist, line_o} == (pat ^ {8{s_q.prev}}))
  ) else $error("preamble pattern wrong");

  chk_pre_violates: assert property (
    (run_i && ui_sub_i == spdenc_pkg::UI_DATA_FIRST)
    |-> (s_q.hist[6:4] == 3'h0 || s_q.hist[6:4] == 3'h7)
  ) else $error("preamble lacks bi-phase violation");

  cov_pre_high: cover property (run_i && ui_sub_i == 6'h00 && line_o);

endmodule

`default_nettype wire

// *** dv/spdenc_rx_model.sv ***
// partner model: receiver that splits the coded line into subframes
`timescale 1ns/100ps
`default_nettype none

module spdenc_rx_model (
  input  wire logic   clk_i,
  input  wire logic   line_i,
  output logic        sub_o,
  output logic [7:0]  pre_o,
  output logic [27:0] data_o,
  output logic        ok_o,
  output logic [6:0]  len_o
);
  logic [72:0] sh  = '0;
  logic [6:0]  cnt = 7'h7f;

  // ************************************************************
  // preamble search and bi-phase decoding
  // ************************************************************
  always @(posedge clk_i) begin : rx
    logic [72:0] s;
    logic [7:0]  p;
    logic        okv;
    s = {sh[71:0], line_i};
    p = s[7:0] ^ {8{s[8]}};
    sh <= s;
    sub_o <= 1'b0;
    cnt <= (cnt == 7'h7f) ? cnt : cnt + 7'h01;
    if (p == spdenc_pkg::PAT_X || p == spdenc_pkg::PAT_Y
        || p == spdenc_pkg::PAT_Z) begin
      cnt <= 7'h00;
      okv = 1'b1;
      for (int k = 4; k < 32; k++) begin
        data_o[k-4] <= s[71-2*k] ^ s[70-2*k];
        okv &= (s[71-2*k] != s[72-2*k]);
      end
      sub_o <= (cnt != 7'h7f);
      pre_o <= s[71:64] ^ {8{s[72]}};
      ok_o <= okv;
      len_o <= cnt + 7'h01;
    end
  end
endmodule

`default_nettype wire

// *** dv/test_spdif_subframe_encoder.sv ***
// testbench: register writes, sample pairs and decoded line checks
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
  $display("Error at %0t: got %h want %h", $time, a, b); end end

module test_spdif_subframe_encoder;
  logic        clk   = 1'b0;
  logic        rst   = 1'b1;
  logic [7:0]  addr  = 8'h00;
  logic        rd    = 1'b0;
  logic        wr    = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        wait_req;
  logic        line;
  logic        sub;
  logic        ok;
  logic [7:0]  pre;
  logic [27:0] data;
  logic [6:0]  len;
  logic [35:0] q[$];
  logic [35:0] e;
  logic [31:0] rv, ctl, csa, csb, sr, smp_a, smp_b;
  int          mismatches = 0;
  int          checked    = 0;
  int          cycles     = 0;
  int          seed       = 32'hc98f;
  logic [31:0] cfgs[4]    = '{32'h602, 32'h41a, 32'h52c, 32'h4b0};

  // ************************************************************
  // clock, design and partner
  // ************************************************************
  always #5 clk = ~clk;

  spdenc_encoder #(.BLOCK_FRAMES(4)) spdenc_encoder_i (
    .CLK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hf),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_req), .TX_LINE_O(line));

  spdenc_rx_model spdenc_rx_model_i (.clk_i(clk), .line_i(line), .sub_o(sub),
    .pre_o(pre), .data_o(data), .ok_o(ok), .len_o(len));

  // ************************************************************
  // bus access, expectations, report
  // ************************************************************
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    do @(posedge clk); while (wait_req !== 1'b0);
    rv = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [35:0] exps(logic [23:0] smp, logic [5:0] sd, logic sb,
                                       logic cs, logic z);
    logic [27:0] d;
    int          w;
    w = ctl[10:6];
    if (ctl[1]) d[23:0] = smp & ~((24'h1 << (24 - w)) - 24'h1);
    else d[23:0] = {smp[23:4] & ~((20'h1 << (20 - w)) - 20'h1), sd[5:2]};
    d[24] = sd[0] | (ctl[3] & ctl[4 + sb]);
    d[25] = sd[1];
    d[26] = cs;
    d[27] = ^d[26:0];
    return {sb ? spdenc_pkg::PAT_Y : (z ? spdenc_pkg::PAT_Z : spdenc_pkg::PAT_X), d};
  endfunction

  task automatic final_report();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      final_report();
    end
  end

  // ************************************************************
  // monitor: decoded subframes against oldest note
  // ************************************************************
  always @(posedge clk) begin
    if (sub === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      `CHK(pre, e[35:28])
      `CHK(data, e[27:0])
      `CHK(len, 7'h40)
      `CHK(ok, 1'b1)
    end
  end

  // ************************************************************
  // main sequence: four modes, six frames each
  // ************************************************************
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, spdenc_pkg::OFS_CTRL, 32'h0);
    `CHK(rv, spdenc_pkg::CTRL_RST)
    bus(1'b0, 8'h80, 32'h0);
    `CHK(rv, 32'h0)
    foreach (cfgs[i]) begin
      ctl = cfgs[i];
      csa = $random(seed);
      csb = $random(seed);
      bus(1'b1, spdenc_pkg::OFS_CTRL, ctl);
      bus(1'b1, spdenc_pkg::OFS_CHST_A, csa);
      bus(1'b1, spdenc_pkg::OFS_CHST_B, csb);
      for (int f = 0; f < 6; f++) begin
        smp_a = $random(seed);
        smp_b = $random(seed);
        sr = $random(seed);
        bus(1'b1, spdenc_pkg::OFS_LEFT, smp_a);
        bus(1'b1, spdenc_pkg::OFS_SIDE, sr);
        bus(1'b1, ctl[2] ? spdenc_pkg::OFS_LEFT : spdenc_pkg::OFS_RIGHT, smp_b);
        q.push_back(exps(smp_a[23:0], sr[5:0], 1'b0, csa[f % 4], f % 4 == 0));
        q.push_back(exps(smp_b[23:0], sr[11:6], 1'b1, csb[f % 4], 1'b0));
        if (f == 0) bus(1'b1, spdenc_pkg::OFS_CTRL, ctl | 32'h1);
      end
      while (q.size() != 0) @(posedge clk);
      bus(1'b1, spdenc_pkg::OFS_CTRL, ctl);
      repeat (150) @(posedge clk);
    end
    final_report();
  end
endmodule

`default_nettype wire

// *** pkg/spdenc_pkg.sv ***
// package: offsets, fields, reset values and types of the subframe encoder
package spdenc_pkg;

  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STAT   = 8'h04;
  localparam logic [7:0] OFS_LEFT   = 8'h08;
  localparam logic [7:0] OFS_RIGHT  = 8'h0c;
  localparam logic [7:0] OFS_SIDE   = 8'h10;
  localparam logic [7:0] OFS_CHST_A = 8'h40;
  localparam logic [7:0] OFS_CHST_B = 8'h60;

  // ************************************************************
  // reset values, field positions, counts
  // ************************************************************
  localparam logic [31:0] CTRL_RST       = 32'h0000_0602;
  localparam int unsigned STAT_UNDER_BIT = 1;
  localparam int unsigned BLOCK_FRAMES   = 192;
  localparam int unsigned CHST_BITS      = 192;
  localparam int unsigned CHST_WORDS     = 6;
  localparam logic [6:0]  UI_FRAME_LAST  = 7'h7f;
  localparam logic [6:0]  UI_SUB_LAST    = 7'h3f;
  localparam logic [5:0]  UI_DATA_FIRST  = 6'h08;
  localparam logic [4:0]  WIDTH_24       = 5'h18;
  localparam logic [4:0]  WIDTH_20       = 5'h14;
  localparam logic [4:0]  SLOT_VALID     = 5'h1c;
  localparam logic [4:0]  SLOT_USER      = 5'h1d;
  localparam logic [4:0]  SLOT_CHST      = 5'h1e;
  localparam logic [4:0]  SLOT_PARITY    = 5'h1f;
  localparam logic [7:0]  PAT_X          = 8'he2;
  localparam logic [7:0]  PAT_Y          = 8'he4;
  localparam logic [7:0]  PAT_Z          = 8'he8;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    PRE_X = 2'b00,
    PRE_Y = 2'b01,
    PRE_Z = 2'b11
  } spdenc_pre_t;

  typedef enum logic {
    RUN_IDLE   = 1'b0,
    RUN_ACTIVE = 1'b1
  } spdenc_run_t;

  typedef struct packed {
    logic [20:0] rsvd;
    logic [4:0]  width;
    logic        val_b;
    logic        val_a;
    logic        channel_status_buffer_enable;
    logic        single_channel_double_rate;
    logic        mode24;
    logic        enable;
  } spdenc_ctrl_t;

  typedef struct packed {
    logic [3:0] aux;
    logic       user;
    logic       valid;
  } spdenc_side_t;

  typedef struct packed {
    logic [23:0]  smp;
    spdenc_side_t side;
  } spdenc_chan_t;

  typedef struct packed {
    logic       line;
    logic       prev;
    logic [6:0] hist;
  } spdenc_line_st_t;

endpackage
